// ---- flash_block_self_write.sv ----
// flash self-write sequencer: holding registers, unlock, erase and program
//
// Overview of operation
// [R1] words in protected segments are never written
// [R2] groups are four words, slot bits zero-aligned
// [R3] erase sixteen-word row, program four, block-aligned
// [R4] software loads address, then data registers
// [R5] start needs keys 55h then AAh, adjacent
// [R6] start on slots zero to two fills buffer
// [R7] software reloads unchanged words into buffer
// [R8] commit only when start hits slot three
// [R9] software writes slots in ascending order
// [R10] last-slot start erases row then programs buffer
// [R11] two setup cycles follow start, software waits
// [R12] buffer loads never stall the core
// [R13] core stalls during erase, clocks keep running
// [R14] core resumes after four-word programming ends
// [R15] software repeats groups for remaining twelve words
// [R16] write enable clears at power-up
// [R17] power-up timer blocks all writes
// [R18] start needs enable bit and full unlock
// [R19] unlock port stores nothing, reads zero
// [R20] start bit holds until operation ends
// [R21] bad start leaves buffer and flash untouched
`timescale 1ns/10ps
module flash_block_self_write
  import flash_self_write_pkg::*;
#(
  parameter int ERASE_CYC = ERASE_CYC_DFLT,  // erase stall length
  parameter int PWRT_CYC  = PWRT_CYC_DFLT    // power-up lockout length
) (
  // clock, enable and reset
  input  wire logic              clock,
  input  wire logic              ce,
  input  wire logic              nrst,
  // register port
  input  wire logic [2:0]        regAddr,
  input  wire logic [7:0]        regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [7:0]        regRdata,
  // segment protection, one bit per segment
  input  wire logic [SEGS-1:0]   segProtect,
  // core stall
  output logic                   cpuStall,
  // flash array side
  output logic                   flashErase,
  output logic                   flashProg,
  output logic      [ADDR_W-1:0] flashAddr,
  output logic      [WORD_W-1:0] flashData
);

  // decode of a register write at one offset
  function automatic logic wrHit(input logic [2:0] ofs);
    return regWr && (regAddr == ofs);
  endfunction : wrHit

  // software-visible holding and control state
  logic [7:0]           addrLow_q;     // address low holding register
  logic [ADDR_HI_W-1:0] addrHigh_q;    // address high holding register
  logic [7:0]           dataLow_q;     // data low holding register
  logic [DATA_HI_W-1:0] dataHigh_q;    // data high holding register
  logic                 writeEnable_q; // write enable bit
  logic                 start_q;       // write start bit
  key_state_e           key_q;         // unlock detector
  seq_state_e           state_q;       // sequencer state
  // timers and the latched operation
  logic [20:0]          cnt_q;         // phase timer
  logic [20:0]          pwrt_q;        // power-up timer
  logic                 pwrtDone_q;    // power-up lockout over
  logic [SLOT_W-1:0]    slot_q;        // slot of the accepted start
  logic [ADDR_W-1:0]    opAddr_q;      // address of the accepted start
  logic [WORD_W-1:0]    opData_q;      // word of the accepted start
  logic [SLOT_W-1:0]    progIdx_q;     // slot being programmed
  logic [WORD_W-1:0]    bufRdata;      // buffer read data
  // combinational decode
  logic [ADDR_W-1:0]    holdAddr;      // assembled holding address
  logic                 segLocked;     // target segment is protected
  logic                 startReq;      // software tries to set start
  logic                 startOk;       // start accepted
  logic                 bufWr;         // buffer slot write

  // target from the holding pair, segment from its top bits
  assign holdAddr  = {addrHigh_q, addrLow_q};
  assign segLocked = segProtect[holdAddr[ADDR_W-1 -: SEG_W]];
  assign startReq  = wrHit(CTRL_OFS) && regWdata[START_BIT];

  // accept a start only with full unlock, enable and free target
  assign startOk = startReq && (key_q == UK_OPEN)  // R5 R18 R21
                && writeEnable_q                    // R18 R21
                && pwrtDone_q                       // R17
                && !segLocked                       // R1
                && (state_q == ST_IDLE);            // R20

  // address and data holding registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      addrLow_q  <= BYTE_RST;
      addrHigh_q <= '0;
      dataLow_q  <= BYTE_RST;
      dataHigh_q <= '0;
    end else if (ce) begin
      // address low byte
      if (wrHit(ADDR_LOW_OFS)) begin
        addrLow_q <= regWdata;
      end
      // address high bits, the rest dropped
      if (wrHit(ADDR_HIGH_OFS)) begin
        addrHigh_q <= regWdata[ADDR_HI_W-1:0];
      end
      // data low byte
      if (wrHit(DATA_LOW_OFS)) begin
        dataLow_q <= regWdata;
      end
      // data high bits, the rest dropped
      if (wrHit(DATA_HIGH_OFS)) begin
        dataHigh_q <= regWdata[DATA_HI_W-1:0];
      end
    end
  end

  // write enable bit, cleared by reset
  always_ff @(posedge clock) begin
    if (!nrst) begin
      writeEnable_q <= 1'b0;  // R16
    end else if (ce && wrHit(CTRL_OFS)) begin
      // every control write also rewrites the enable bit
      writeEnable_q <= regWdata[WRITE_ENABLE_BIT_BIT];
    end
  end

  // unlock detector: 55h then aah, any other write breaks it
  always_ff @(posedge clock) begin
    if (!nrst) begin
      key_q <= UK_NONE;
    end else if (ce && regWr) begin
      // only writes are watched; reads leave the detector alone
      if (regAddr == UNLOCK_OFS) begin  // R19
        unique case (key_q)
          // waiting for the first key
          UK_NONE: begin
            key_q <= (regWdata == KEY_FIRST) ? UK_FIRST : UK_NONE;  // R5
          end
          // first key seen, a repeat of it restarts
          UK_FIRST: begin
            key_q <= (regWdata == KEY_SECOND) ? UK_OPEN  // R5
                   : (regWdata == KEY_FIRST) ? UK_FIRST : UK_NONE;
          end
          // open: only the very next control write may use it
          UK_OPEN: begin
            key_q <= (regWdata == KEY_FIRST) ? UK_FIRST : UK_NONE;
          end
        endcase
      end else begin
        // any other register write consumes or breaks the unlock
        key_q <= UK_NONE;  // R21
      end
    end
  end

  // power-up timer lockout
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pwrt_q     <= CNT_ZERO;
      pwrtDone_q <= 1'b0;
    end else if (ce && !pwrtDone_q) begin
      // counts only while enabled, stops once done
      pwrt_q <= pwrt_q + 21'h000001;
      // starts before this point are simply dropped
      if (pwrt_q == 21'(PWRT_CYC - 1)) begin
        pwrtDone_q <= 1'b1;  // R17
      end
    end
  end

  // latch the target of an accepted start
  always_ff @(posedge clock) begin
    if (!nrst) begin
      slot_q   <= '0;
      opAddr_q <= '0;
      opData_q <= '0;
    end else if (ce && startOk) begin
      // slot, address and word stay frozen for the whole operation
      slot_q   <= holdAddr[SLOT_W-1:0];
      opAddr_q <= holdAddr;
      opData_q <= {dataHigh_q, dataLow_q};
    end
  end

  // start bit stays set for the whole operation
  always_ff @(posedge clock) begin
    if (!nrst) begin
      start_q <= 1'b0;
    end else if (ce) begin
      // a plain load clears in its load cycle, after setup; a commit holds to its last word
      if (startOk) begin
        start_q <= 1'b1;  // R20
      end else if ((state_q == ST_LOAD && slot_q != LAST_SLOT) ||
                   (state_q == ST_PROG && progIdx_q == LAST_SLOT &&
                    cnt_q == 21'(PROG_CYC - 1))) begin
        start_q <= 1'b0;  // R20
      end
    end
  end

  // sequencer: setup, buffer load, then for the last slot erase and program
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q   <= ST_IDLE;
      cnt_q     <= CNT_ZERO;
      progIdx_q <= '0;
    end else if (ce) begin
      unique case (state_q)
        ST_IDLE: begin
          // wait for an accepted start
          cnt_q <= CNT_ZERO;
          if (startOk) begin
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // two cycles to prepare before anything moves
          cnt_q <= cnt_q + 21'h000001;
          if (cnt_q == 21'(SETUP_CYC - 1)) begin  // R11
            cnt_q   <= CNT_ZERO;
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // slot written; only the last slot goes on to commit
          if (slot_q == LAST_SLOT) begin  // R8 R10
            state_q <= ST_ERASE;
          end else begin
            state_q <= ST_IDLE;  // R12
          end
        end
        ST_ERASE: begin
          // row erase under stall, clocks keep running
          cnt_q <= cnt_q + 21'h000001;
          if (cnt_q == 21'(ERASE_CYC - 1)) begin  // R13
            cnt_q     <= CNT_ZERO;
            progIdx_q <= '0;
            state_q   <= ST_PROG;  // R10
          end
        end
        ST_PROG: begin
          // one program slot per word, ascending
          cnt_q <= cnt_q + 21'h000001;
          if (cnt_q == 21'(PROG_CYC - 1)) begin
            cnt_q     <= CNT_ZERO;
            progIdx_q <= progIdx_q + 2'h1;
            // the last word hands the core back
            if (progIdx_q == LAST_SLOT) begin
              state_q <= ST_IDLE;  // R14
            end
          end
        end
        default: begin
          // a stray code falls back to idle
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // buffer slot is loaded only after a valid start
  assign bufWr = (state_q == ST_LOAD);  // R6 R21

  // four-slot store between the holding registers and the flash
  word_buffer_mem word_buffer_mem_i (
    .clock  (clock),
    .ce     (ce),
    .nrst   (nrst),
    .write_enable_bit   (bufWr),
    .wrSlot (slot_q),
    .wrData (opData_q),
    .rdSlot (progIdx_q),
    .rdData (bufRdata)
  );

  // stall covers erase and program only
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cpuStall <= 1'b0;
    end else if (ce) begin
      // a slot-three load raises the stall with the erase pulse
      // and it drops on the last program cycle, as start clears
      cpuStall <= (state_q == ST_LOAD && slot_q == LAST_SLOT)  // R13
               || state_q == ST_ERASE
               || (state_q == ST_PROG &&
                   !(progIdx_q == LAST_SLOT &&
                     cnt_q == 21'(PROG_CYC - 1)));  // R14
    end
  end

  // flash array strobes, address and data
  always_ff @(posedge clock) begin
    if (!nrst) begin
      flashErase <= 1'b0;
      flashProg  <= 1'b0;
      flashAddr  <= '0;
      flashData  <= '0;
    end else if (ce) begin
      // strobes default low, so each pulse lasts one cycle
      flashErase <= 1'b0;
      flashProg  <= 1'b0;
      if (state_q == ST_LOAD && slot_q == LAST_SLOT) begin
        // row address, low four bits cleared
        flashErase <= 1'b1;  // R3 R10
        flashAddr  <= {opAddr_q[ADDR_W-1:ROW_LO], {ROW_LO{1'b0}}};
      end else if (state_q == ST_PROG && cnt_q == 21'h000001) begin
        // buffered word goes to its aligned group address
        flashProg <= 1'b1;  // R2 R3
        flashAddr <= {opAddr_q[ADDR_W-1:SLOT_W], progIdx_q};
        flashData <= bufRdata;
      end
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge clock) begin
    if (!nrst) begin
      regRdata <= BYTE_RST;
    end else if (ce) begin
      // nothing selected reads back as zero
      regRdata <= BYTE_RST;
      if (regRd) begin
        unique case (regAddr)
          CTRL_OFS: begin
            // enable and start bits, the others zero
            regRdata[WRITE_ENABLE_BIT_BIT]  <= writeEnable_q;
            regRdata[START_BIT] <= start_q;
          end
          // holding registers, upper bits zero-filled
          ADDR_LOW_OFS:  regRdata <= addrLow_q;
          ADDR_HIGH_OFS: regRdata <= 8'(addrHigh_q);
          DATA_LOW_OFS:  regRdata <= dataLow_q;
          DATA_HIGH_OFS: regRdata <= 8'(dataHigh_q);
          default:       regRdata <= BYTE_RST;  // R19
        endcase
      end
    end
  end

endmodule : flash_block_self_write

// ---- flash_self_write_pkg.sv ----
// constants shared by the flash self-write sequencer and its buffer store
package flash_self_write_pkg;

  // register port offsets
  localparam logic [2:0] CTRL_OFS      = 3'h0;
  localparam logic [2:0] UNLOCK_OFS    = 3'h1;
  localparam logic [2:0] ADDR_LOW_OFS  = 3'h2;
  localparam logic [2:0] ADDR_HIGH_OFS = 3'h3;
  localparam logic [2:0] DATA_LOW_OFS  = 3'h4;
  localparam logic [2:0] DATA_HIGH_OFS = 3'h5;

  // control register fields
  localparam int WRITE_ENABLE_BIT_BIT  = 2;
  localparam int START_BIT = 1;

  // widths of the holding registers
  localparam int ADDR_HI_W = 3;
  localparam int DATA_HI_W = 6;
  localparam int ADDR_W    = 8 + ADDR_HI_W;
  localparam int WORD_W    = 8 + DATA_HI_W;

  // group and row geometry
  localparam int SLOT_W = 2;
  localparam int ROW_LO = 4;
  localparam logic [SLOT_W-1:0] LAST_SLOT = 2'h3;
  localparam int SEG_W  = 2;
  localparam int SEGS   = 4;

  // unlock keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // reset values
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [20:0] CNT_ZERO = 21'h000000;

  // timing
  localparam int CLK_HZ        = 25_000_000;
  localparam int SETUP_CYC     = 2;
  localparam int ERASE_TIME_US = 4_000;
  localparam int PWRT_TIME_MS  = 64;
  localparam int PROG_TIME_NS  = 2_000;
  localparam int ERASE_CYC_DFLT = ERASE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int PWRT_CYC_DFLT  = PWRT_TIME_MS * (CLK_HZ / 1_000);
  localparam int PROG_CYC =
    (PROG_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_LOAD, ST_ERASE, ST_PROG
  } seq_state_e;

  // unlock detector states
  typedef enum logic [1:0] {
    UK_NONE, UK_FIRST, UK_OPEN
  } key_state_e;

endpackage : flash_self_write_pkg

// ---- word_buffer_mem.sv ----
// four-slot word buffer with a registered read port
`timescale 1ns/10ps
module word_buffer_mem
  import flash_self_write_pkg::*;
(
  // clock, enable and reset
  input  wire logic              clock,
  input  wire logic              ce,
  input  wire logic              nrst,
  // write port
  input  wire logic              write_enable_bit,
  input  wire logic [SLOT_W-1:0] wrSlot,
  input  wire logic [WORD_W-1:0] wrData,
  // read port
  input  wire logic [SLOT_W-1:0] rdSlot,
  output logic      [WORD_W-1:0] rdData
);

  logic [WORD_W-1:0] mem [SEGS];  // one word per slot

  // slot storage, holds its contents across resets
  always_ff @(posedge clock) begin
    if (ce && write_enable_bit) begin
      mem[wrSlot] <= wrData;
    end
  end

  // registered read data
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdData <= '0;
    end else if (ce) begin
      rdData <= mem[rdSlot];
    end
  end

endmodule : word_buffer_mem

// ---- flash_block_self_write_asserts.sv ----
// port assertions for the flash self-write sequencer
`timescale 1ns/10ps
module flash_block_self_write_asserts
  import flash_self_write_pkg::*;
#(
  parameter int ERASE_CYC = ERASE_CYC_DFLT,  // erase stall length
  parameter int PWRT_CYC  = PWRT_CYC_DFLT    // power-up lockout length
) (
  // clock, enable and reset
  input wire logic              clock,
  input wire logic              ce,
  input wire logic              nrst,
  // register port
  input wire logic [2:0]        regAddr,
  input wire logic [7:0]        regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [7:0]        regRdata,
  // protection, stall and flash side
  input wire logic [SEGS-1:0]   segProtect,
  input wire logic              cpuStall,
  input wire logic              flashErase,
  input wire logic              flashProg,
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic [WORD_W-1:0] flashData
);
  logic [31:0] upCnt_q;  // enabled cycles since reset release

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // count up to the lockout length, then hold
  always_ff @(posedge clock) begin
    if (!nrst) upCnt_q <= 32'h0;
    else if (ce && upCnt_q < PWRT_CYC) upCnt_q <= upCnt_q + 32'h1;
  end

  a_lockout_erase: assert property (flashErase |-> upCnt_q >= PWRT_CYC)
    else $error("erase while lockout still running");
  a_erase_cause: assert property (flashErase |-> $past(regWr &&
    regAddr == CTRL_OFS && regWdata[START_BIT], 4))
    else $error("erase without a start write four cycles before");
  a_erase_row: assert property (flashErase |-> flashAddr[3:0] == 4'h0)
    else $error("erase address not row aligned");
  a_erase_unprot: assert property (flashErase |->
    !segProtect[flashAddr[ADDR_W-1 -: SEG_W]])
    else $error("erase inside a protected segment");
  a_prog_unprot: assert property (flashProg |->
    !segProtect[flashAddr[ADDR_W-1 -: SEG_W]])
    else $error("program inside a protected segment");
  a_stall_cause: assert property ($rose(cpuStall) |-> flashErase)
    else $error("stall raised without an erase");
  a_erase_stall: assert property (flashErase |-> cpuStall)
    else $error("core not stalled during erase");
  a_prog_stall: assert property (flashProg |-> cpuStall)
    else $error("core resumed before programming ended");
  a_prog_gap: assert property (flashProg |=> !flashProg [*8])
    else $error("program pulses too close together");
  a_unlock_read: assert property ($past(regRd &&
    regAddr == UNLOCK_OFS) |-> regRdata == 8'h00)
    else $error("unlock port read back nonzero");
endmodule : flash_block_self_write_asserts

bind flash_block_self_write flash_block_self_write_asserts #(
  .ERASE_CYC(ERASE_CYC), .PWRT_CYC(PWRT_CYC)
) flash_block_self_write_asserts_i (
  .clock(clock), .ce(ce), .nrst(nrst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .segProtect(segProtect), .cpuStall(cpuStall),
  .flashErase(flashErase), .flashProg(flashProg),
  .flashAddr(flashAddr), .flashData(flashData)
);

// ---- core_model.sv ----
// processor core model issuing self-programming register cycles
`timescale 1ns/10ps
module core_model
  import flash_self_write_pkg::*;
(
  // clock
  input  wire logic       clock,
  // register port
  output logic      [2:0] regAddr,
  output logic      [7:0] regWdata,
  output logic            regWr,
  output logic            regRd,
  input  wire logic [7:0] regRdata
);
  // idle bus at time zero
  initial begin
    regAddr = 3'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // one write cycle, strobe low again on the next edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    regWdata <= ~d;  // released data no longer shows the value
  endtask : wr

  // one read cycle, data taken in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    @(posedge clock);
    d = regRdata;
  endtask : rd

  // full word sequence: address, data, enable, keys, start, two idles
  task automatic word(input logic [ADDR_W-1:0] a,
                      input logic [WORD_W-1:0] d);
    wr(ADDR_LOW_OFS, a[7:0]);
    wr(ADDR_HIGH_OFS, {5'h00, a[10:8]});
    wr(DATA_LOW_OFS, d[7:0]);
    wr(DATA_HIGH_OFS, {2'h0, d[13:8]});
    wr(CTRL_OFS, 8'h04);
    wr(UNLOCK_OFS, KEY_FIRST);
    wr(UNLOCK_OFS, KEY_SECOND);
    wr(CTRL_OFS, 8'h06);
    repeat (2) @(posedge clock);
  endtask : word
endmodule : core_model

// ---- flash_block_self_write_tb.sv ----
// self-checking testbench for the flash self-write sequencer
`timescale 1ns/10ps
module flash_block_self_write_tb
  import flash_self_write_pkg::*;
;
  localparam int ERASE_N = 20;  // shortened erase stall
  localparam int PWRT_N  = 10;  // shortened power-up lockout
  logic              clock;       // system clock
  logic              ce;          // clock enable
  logic              nrst;        // synchronous reset
  logic [2:0]        regAddr;     // register offset
  logic [7:0]        regWdata;    // write data
  logic              regWr;       // write strobe
  logic              regRd;       // read strobe
  logic [7:0]        regRdata;    // read data
  logic [SEGS-1:0]   segProtect;  // segment protect levels
  logic              cpuStall;    // core halt
  logic              flashErase;  // erase pulse
  logic              flashProg;   // program pulse
  logic [ADDR_W-1:0] flashAddr;   // flash address
  logic [WORD_W-1:0] flashData;   // flash word
  logic [ADDR_W-1:0] eraseA;      // last erase address
  logic [ADDR_W-1:0] progA [4];   // program addresses
  logic [WORD_W-1:0] progD [4];   // program words
  logic [7:0]        c;           // read back value
  int failures, checkCount, eraseCnt, progCnt, stallCnt;

  flash_block_self_write #(.ERASE_CYC(ERASE_N), .PWRT_CYC(PWRT_N))
    flash_block_self_write_i (
    .clock(clock), .ce(ce), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .segProtect(segProtect), .cpuStall(cpuStall),
    .flashErase(flashErase), .flashProg(flashProg),
    .flashAddr(flashAddr), .flashData(flashData));

  core_model core_model_i (
    .clock(clock), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

  // clock generator
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // record flash side pulses and stalled cycles
  always @(posedge clock) begin
    if (cpuStall === 1'b1) stallCnt++;
    if (flashErase === 1'b1) begin
      eraseCnt++;
      eraseA = flashAddr;
    end
    if (flashProg === 1'b1) begin
      progA[progCnt % 4] = flashAddr;
      progD[progCnt % 4] = flashData;
      progCnt++;
    end
  end

  function automatic logic [WORD_W-1:0] wordOf(input int i);
    return 14'h2a50 + 14'(i) * 14'h0111;
  endfunction : wordOf

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h",
               $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("mismatches %0d of %0d checks", failures, checkCount);
    if (failures == 0 && checkCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic reset_dut;
    @(posedge clock);
    nrst <= 1'b0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
  endtask : reset_dut

  // start attempted while the power-up timer still runs
  task automatic t_lockout;
    core_model_i.wr(CTRL_OFS, 8'h04);
    core_model_i.wr(UNLOCK_OFS, KEY_FIRST);
    core_model_i.wr(UNLOCK_OFS, KEY_SECOND);
    core_model_i.wr(CTRL_OFS, 8'h06);
    core_model_i.rd(CTRL_OFS, c);
    check(c, 8'h04);
    repeat (PWRT_N) @(posedge clock);
  endtask : t_lockout

  // holding register widths, unlock port and unmapped offset
  task automatic t_regs;
    @(posedge clock);
    ce <= 1'b0;
    core_model_i.wr(ADDR_LOW_OFS, 8'h5a);
    ce <= 1'b1;
    core_model_i.rd(ADDR_LOW_OFS, c);
    check(c, 8'h00);
    core_model_i.wr(ADDR_HIGH_OFS, 8'hff);
    core_model_i.rd(ADDR_HIGH_OFS, c);
    check(c, 8'h07);
    core_model_i.wr(DATA_HIGH_OFS, 8'hff);
    core_model_i.rd(DATA_HIGH_OFS, c);
    check(c, 8'h3f);
    core_model_i.rd(UNLOCK_OFS, c);
    check(c, 8'h00);
    core_model_i.rd(3'h6, c);
    check(c, 8'h00);
  endtask : t_regs

  // one aligned group, slots zero to three, commit on the last
  task automatic t_group(input logic [ADDR_W-1:0] base);
    int n, s0, e0, p0;
    s0 = stallCnt;
    e0 = eraseCnt;
    p0 = progCnt;
    for (int i = 0; i < 4; i++) begin
      core_model_i.word(base + 11'(i), wordOf(int'(base[3:0]) + i));
      if (i < 3) begin
        core_model_i.rd(CTRL_OFS, c);
        check(c, 8'h04);
        check(stallCnt - s0, 0);
        check(eraseCnt - e0, 0);
      end
    end
    core_model_i.rd(CTRL_OFS, c);
    check(c, 8'h06);
    n = 0;
    while (cpuStall === 1'b1 && n < 1000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 1000) begin
      failures++;
      print_verdict();
    end
    check(eraseCnt - e0, 1);
    check(eraseA, {base[ADDR_W-1:ROW_LO], 4'h0});
    check(progCnt - p0, 4);
    for (int i = 0; i < 4; i++) begin
      check(progA[i], base + 11'(i));
      check(progD[i], wordOf(int'(base[3:0]) + i));
    end
    check(stallCnt - s0 >= ERASE_N + 4 * PROG_CYC - 1 &&
          stallCnt - s0 <= ERASE_N + 4 * PROG_CYC + 1, 1);
    core_model_i.rd(CTRL_OFS, c);
    check(c, 8'h04);
  endtask : t_group

  // starts without keys, without enable, split keys, protected segment
  task automatic t_refuse;
    core_model_i.wr(ADDR_LOW_OFS, 8'h17);
    core_model_i.wr(ADDR_HIGH_OFS, 8'h02);
    for (int m = 0; m < 4; m++) begin
      @(posedge clock);
      segProtect <= (m == 3) ? 4'h2 : 4'h0;
      core_model_i.wr(CTRL_OFS, (m == 1) ? 8'h00 : 8'h04);
      if (m != 0) core_model_i.wr(UNLOCK_OFS, KEY_FIRST);
      if (m == 2) core_model_i.wr(ADDR_LOW_OFS, 8'h17);
      if (m != 0) core_model_i.wr(UNLOCK_OFS, KEY_SECOND);
      core_model_i.wr(CTRL_OFS, (m == 1) ? 8'h02 : 8'h06);
      core_model_i.rd(CTRL_OFS, c);
      check(c, (m == 1) ? 8'h00 : 8'h04);
      repeat (8) @(posedge clock);
      check(eraseCnt + progCnt, 10);
    end
    @(posedge clock);
    segProtect <= 4'h0;
  endtask : t_refuse

  // main sequence
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    segProtect = 4'h0;
    {failures, checkCount, eraseCnt, progCnt, stallCnt} = '0;
    reset_dut();
    t_lockout();
    t_regs();
    t_group(11'h214);
    t_group(11'h218);
    t_refuse();
    reset_dut();
    core_model_i.rd(CTRL_OFS, c);
    check(c, 8'h00);
    print_verdict();
  end
endmodule : flash_block_self_write_tb
